// ===== hw/lest_pkg.sv
// constants for the laser enable, status and tickle block
// assumes a single 250 MHz clock and 32-bit Avalon-MM register access
package lest_pkg;

   // clock
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned CLK_PERIOD_NS = 4;

   // timing figures as printed, and their cycle counts
   localparam int unsigned TICKLE_WIN_US = 200;
   localparam int unsigned TICKLE_WIN_CYC = TICKLE_WIN_US * (CLK_HZ / 1_000_000);
   localparam int unsigned TICKLE_PULSE_NS = 4000;
   localparam int unsigned TICKLE_PULSE_CYC = TICKLE_PULSE_NS / CLK_PERIOD_NS;
   localparam int unsigned INHIBIT_S = 5;
   localparam int unsigned INHIBIT_CYC = INHIBIT_S * CLK_HZ;

   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
   localparam logic [7:0] REG_TICKLE_LEN = 8'h10;

   // control fields
   localparam int CTRL_TICKLE_EN = 0;
   localparam int CTRL_SW_HOLD = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;

   // status fields
   localparam int STAT_READY = 0;
   localparam int STAT_ARMED = 1;
   localparam int STAT_LASING = 2;
   localparam int STAT_OVER_TEMP = 3;
   localparam int STAT_ILK_OPEN = 4;
   localparam int STAT_TICKLE = 5;

   // event fields, shared by irq status and mask
   localparam int EVT_READY_RISE = 0;
   localparam int EVT_ARMED = 1;
   localparam int EVT_ILK_LOST = 2;
   localparam int EVT_OVER_TEMP = 3;
   localparam int EVT_TICKLE = 4;
   localparam int EVT_W = 5;
   localparam logic [EVT_W-1:0] IRQ_MASK_RESET = 5'h00;

   // synchronised input bits
   localparam int IN_PWM = 0;
   localparam int IN_RESET = 1;
   localparam int IN_ILK = 2;
   localparam int IN_TEMP = 3;
   localparam int IN_W = 4;

   typedef enum logic [1:0] {
      LEST_DISABLED,
      LEST_INHIBIT,
      LEST_ARMED
   } lest_state_e;

endpackage

// ===== hw/lest_sync.sv
// two-flop synchroniser bank for the optoisolated inputs
// assumes inputs are quiet levels; no filtering is done here
`timescale 1ns/10ps
module lest_sync
   import lest_pkg::*;
#(
   parameter int WIDTH = 4
)
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // raw and synchronised levels
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         // first stage feeds only the second stage
         always_ff @(posedge ref_clk_i)
         begin
            if (reset_i)
            begin
               meta_q[i] <= 1'b0;
               sync_q[i] <= 1'b0;
            end
            else
            begin
               meta_q[i] <= async_i[i];
               sync_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   assign sync_o = sync_q;

endmodule

// ===== hw/lest_top.sv
// laser enable sequencing, tickle generator and status switches
// assumes one 250 MHz clock, synchronous reset and an Avalon-MM master
//
// Overview of operation
// - tickle when command off longer than 200 us
// - tickle is short pulse, length set in REG_TICKLE_LEN, may merge
// - tickle decided by off time, not frequency
// - reset input holds disabled; release starts 5 s
// - lasing only while interlock input asserted
// - lasing switch closed while beam emitted
// - over-temperature switch follows temperature fault
// - ready closed while enabled, including the 5 s inhibit
// - interlock-open switch closed while interlock open
// - lase per command once armed after the inhibit, up to 100 kHz
// - tickle only if 200 us on-time below preset
// - command held high keeps drive on
`timescale 1ns/10ps
module lest_top
   import lest_pkg::*;
#(
   parameter int unsigned INHIBIT_CYCLES = INHIBIT_CYC,
   parameter int unsigned TICKLE_WIN_CYCLES = TICKLE_WIN_CYC
)
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // optoisolated user inputs and internal temperature fault
   input wire logic pwm_cmd_i,
   input wire logic remote_reset_i,
   input wire logic interlock_i,
   input wire logic over_temp_i,
   // rf drive towards the amplifiers
   output logic rf_drive_o,
   output logic tickle_o,
   // status switches, high means closed
   output logic lasing_o,
   output logic over_temp_o,
   output logic ready_o,
   output logic interlock_open_o,
   // avalon-mm slave
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // interrupt
   output logic irq_o
);

   logic [IN_W-1:0] raw_in;
   logic [IN_W-1:0] sync_in;
   logic pwm_s;
   logic rst_s;
   logic ilk_s;
   logic temp_s;

   assign raw_in = {over_temp_i, interlock_i, remote_reset_i, pwm_cmd_i};

   lest_sync #(
      .WIDTH(IN_W)
   ) u_sync (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .async_i(raw_in),
      .sync_o(sync_in)
   );

   assign pwm_s = sync_in[IN_PWM];
   assign rst_s = sync_in[IN_RESET];
   assign ilk_s = sync_in[IN_ILK];
   assign temp_s = sync_in[IN_TEMP];

   // software-visible control
   logic [1:0] ctrl_q, ctrl_d;
   logic [15:0] tickle_len_q, tickle_len_d;
   logic [EVT_W-1:0] irq_stat_q, irq_stat_d;
   logic [EVT_W-1:0] irq_mask_q, irq_mask_d;

   // core state
   lest_state_e state_q, state_d;
   logic [31:0] inhibit_cnt_q, inhibit_cnt_d;
   logic [31:0] off_cnt_q, off_cnt_d;
   logic [15:0] tickle_cnt_q, tickle_cnt_d;
   logic tickle_q, tickle_d;
   logic ready_q, ready_d;
   logic lasing_q, lasing_d;
   logic temp_q, temp_d;
   logic ilk_open_q, ilk_open_d;
   logic drive_q, drive_d;
   logic irq_q, irq_d;
   logic [EVT_W-1:0] evt;

   // bus
   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic wr_take;
   logic [5:0] status_vec;

   // ---------------- sequencing, tickle and status ----------------
   always_comb
   begin
      state_d = state_q;
      inhibit_cnt_d = inhibit_cnt_q;
      off_cnt_d = off_cnt_q;
      tickle_cnt_d = tickle_cnt_q;
      tickle_d = tickle_q;
      evt = '0;

      case (state_q)
         LEST_DISABLED:
         begin
            inhibit_cnt_d = 32'h0;
            // interlock is not latched: reapplying it restarts the delay
            if (!rst_s && ilk_s && !ctrl_q[CTRL_SW_HOLD])
            begin
               state_d = LEST_INHIBIT;
               evt[EVT_READY_RISE] = 1'b1;
            end
         end
         LEST_INHIBIT:
         begin
            if (rst_s || !ilk_s || ctrl_q[CTRL_SW_HOLD])
            begin
               state_d = LEST_DISABLED;
            end
            else if (inhibit_cnt_q >= INHIBIT_CYCLES - 1)
            begin
               state_d = LEST_ARMED;
               evt[EVT_ARMED] = 1'b1;
            end
            else
            begin
               inhibit_cnt_d = inhibit_cnt_q + 32'h1;
            end
         end
         LEST_ARMED:
         begin
            if (rst_s || !ilk_s || ctrl_q[CTRL_SW_HOLD])
            begin
               state_d = LEST_DISABLED;
            end
         end
         default:
         begin
            state_d = LEST_DISABLED;
         end
      endcase

      if (state_q != LEST_DISABLED && !ilk_s)
      begin
         evt[EVT_ILK_LOST] = 1'b1;
      end
      if (temp_s && !temp_q)
      begin
         evt[EVT_OVER_TEMP] = 1'b1;
      end

      // off time is measured from the falling edge of the command, the end of a tickle or entry to armed;
      // a full window with no command means zero on-time in that window,
      // which is below any preset tickle amount
      if (pwm_s || tickle_q || state_q != LEST_ARMED)
      begin
         off_cnt_d = 32'h0;
      end
      else if (off_cnt_q < TICKLE_WIN_CYCLES)
      begin
         off_cnt_d = off_cnt_q + 32'h1;
      end

      if (tickle_q)
      begin
         // runs to its end even if a command pulse starts meanwhile;
         // a disable in this cycle cuts it, so it never outlives the drive
         if (tickle_cnt_q <= 16'h1 || state_d != LEST_ARMED)
         begin
            tickle_d = 1'b0;
            tickle_cnt_d = 16'h0;
         end
         else
         begin
            tickle_cnt_d = tickle_cnt_q - 16'h1;
         end
      end
      else if (off_cnt_q >= TICKLE_WIN_CYCLES && !pwm_s && ctrl_q[CTRL_TICKLE_EN]
               && tickle_len_q != 16'h0 && state_d == LEST_ARMED)
      begin
         tickle_d = 1'b1;
         tickle_cnt_d = tickle_len_q;
         evt[EVT_TICKLE] = 1'b1;
      end

      // command high for any length keeps the drive on
      drive_d = (state_d == LEST_ARMED) && (pwm_s || tickle_d);
      lasing_d = (state_d == LEST_ARMED) && pwm_s;
      temp_d = temp_s;
      ready_d = (state_d != LEST_DISABLED);
      ilk_open_d = !ilk_s;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         state_q <= LEST_DISABLED;
         inhibit_cnt_q <= 32'h0;
         off_cnt_q <= 32'h0;
         tickle_cnt_q <= 16'h0;
         tickle_q <= 1'b0;
         drive_q <= 1'b0;
         lasing_q <= 1'b0;
         temp_q <= 1'b0;
         ready_q <= 1'b0;
         ilk_open_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         inhibit_cnt_q <= inhibit_cnt_d;
         off_cnt_q <= off_cnt_d;
         tickle_cnt_q <= tickle_cnt_d;
         tickle_q <= tickle_d;
         drive_q <= drive_d;
         lasing_q <= lasing_d;
         temp_q <= temp_d;
         ready_q <= ready_d;
         ilk_open_q <= ilk_open_d;
      end
   end

   // ---------------- avalon slave and interrupt ----------------
   // request is answered by dropping waitrequest for one cycle; the write
   // lands on the edge where the master sees it low
   assign wr_take = avs_write_i && !wait_q;
   assign status_vec = {tickle_q, ilk_open_q, temp_q, lasing_q, state_q == LEST_ARMED, ready_q};

   always_comb
   begin
      ctrl_d = ctrl_q;
      tickle_len_d = tickle_len_q;
      irq_mask_d = irq_mask_q;
      irq_stat_d = irq_stat_q;
      rdata_d = rdata_q;
      wait_d = !((avs_read_i || avs_write_i) && wait_q);

      if (avs_read_i && wait_q)
      begin
         case (avs_address_i)
            REG_CTRL: rdata_d = {30'h0, ctrl_q};
            REG_STATUS: rdata_d = {26'h0, status_vec};
            REG_IRQ_STAT: rdata_d = {27'h0, irq_stat_q};
            REG_IRQ_MASK: rdata_d = {27'h0, irq_mask_q};
            REG_TICKLE_LEN: rdata_d = {16'h0, tickle_len_q};
            default: rdata_d = 32'h0;
         endcase
      end

      if (wr_take && avs_address_i == REG_CTRL && avs_byteenable_i[0])
      begin
         ctrl_d = avs_writedata_i[1:0];
      end
      if (wr_take && avs_address_i == REG_IRQ_MASK && avs_byteenable_i[0])
      begin
         irq_mask_d = avs_writedata_i[EVT_W-1:0];
      end
      if (wr_take && avs_address_i == REG_TICKLE_LEN)
      begin
         if (avs_byteenable_i[0])
         begin
            tickle_len_d[7:0] = avs_writedata_i[7:0];
         end
         if (avs_byteenable_i[1])
         begin
            tickle_len_d[15:8] = avs_writedata_i[15:8];
         end
      end
      if (wr_take && avs_address_i == REG_IRQ_STAT && avs_byteenable_i[0])
      begin
         irq_stat_d = irq_stat_q & ~avs_writedata_i[EVT_W-1:0];
      end
      // a new event wins over a simultaneous clear
      irq_stat_d = irq_stat_d | evt;
      irq_d = |(irq_stat_d & irq_mask_d);
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         ctrl_q <= CTRL_RESET;
         tickle_len_q <= 16'(TICKLE_PULSE_CYC);
         irq_mask_q <= IRQ_MASK_RESET;
         irq_stat_q <= '0;
         rdata_q <= 32'h0;
         wait_q <= 1'b1;
         irq_q <= 1'b0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         tickle_len_q <= tickle_len_d;
         irq_mask_q <= irq_mask_d;
         irq_stat_q <= irq_stat_d;
         rdata_q <= rdata_d;
         wait_q <= wait_d;
         irq_q <= irq_d;
      end
   end

   assign rf_drive_o = drive_q;
   assign tickle_o = tickle_q;
   assign lasing_o = lasing_q;
   assign over_temp_o = temp_q;
   assign ready_o = ready_q;
   assign interlock_open_o = ilk_open_q;
   assign avs_readdata_o = rdata_q;
   assign avs_waitrequest_o = wait_q;
   assign irq_o = irq_q;

endmodule

// ===== tb/lest_top_chk.sv
// port-level checker for the laser enable, status and tickle block
// assumes one clock, synchronous active-high reset, bound to lest_top
`timescale 1ns/10ps
module lest_top_chk
   import lest_pkg::*;
#(
   parameter int unsigned INHIBIT_CYCLES = INHIBIT_CYC,
   parameter int unsigned TICKLE_WIN_CYCLES = TICKLE_WIN_CYC
)
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // user inputs
   input wire logic pwm_cmd_i,
   input wire logic interlock_i,
   input wire logic over_temp_i,
   // drive and status
   input wire logic rf_drive_o,
   input wire logic tickle_o,
   input wire logic lasing_o,
   input wire logic over_temp_o,
   input wire logic ready_o,
   input wire logic interlock_open_o,
   // bus handshake
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic avs_waitrequest_o
);
   int unsigned rdy_cnt_q;

   // cycles since ready closed, saturating
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i || !ready_o)
         rdy_cnt_q <= 0;
      else if (rdy_cnt_q < INHIBIT_CYCLES)
         rdy_cnt_q <= rdy_cnt_q + 1;
   end

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   chk_lase_ready: assert property (lasing_o |-> ready_o && rf_drive_o)
      else $error("lasing without ready or drive");
   chk_drive_ready: assert property (rf_drive_o |-> ready_o)
      else $error("drive while not ready");
   // margin of two covers the output register stages
   chk_inhibit_len: assert property (lasing_o |-> rdy_cnt_q >= INHIBIT_CYCLES - 2)
      else $error("lasing inside inhibit time");
   chk_ilk_open: assert property ((!interlock_i) [*6] |=> interlock_open_o && !ready_o)
      else $error("open interlock not reported");
   chk_ilk_closed: assert property (interlock_i [*6] |=> !interlock_open_o)
      else $error("closed interlock reported open");
   chk_temp_set: assert property (over_temp_i [*6] |=> over_temp_o)
      else $error("over temperature not reported");
   chk_temp_clr: assert property ((!over_temp_i) [*6] |=> !over_temp_o)
      else $error("over temperature stuck");
   chk_no_tickle_on: assert property (pwm_cmd_i [*8] |=> !$rose(tickle_o))
      else $error("tickle while command on");
   chk_tickle_drive: assert property (tickle_o |-> rf_drive_o)
      else $error("tickle without drive");
   chk_wait_drop: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus answer late");
   chk_wait_one: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
endmodule

bind lest_top lest_top_chk #(.INHIBIT_CYCLES(INHIBIT_CYCLES), .TICKLE_WIN_CYCLES(TICKLE_WIN_CYCLES)) chk_u (
   .ref_clk_i, .reset_i, .pwm_cmd_i, .interlock_i, .over_temp_i, .rf_drive_o, .tickle_o, .lasing_o,
   .over_temp_o, .ready_o, .interlock_open_o, .avs_read_i, .avs_write_i, .avs_waitrequest_o
);

// ===== tb/lest_ctrl_model.sv
// machine controller model making the pwm power command
// assumes rates scaled down with the shortened tickle window
`timescale 1ns/10ps
module lest_ctrl_model
(
   // clock
   input wire logic ref_clk_i,
   // gate and waveform shape in cycles
   input wire logic gate_i,
   input int hi_len_i,
   input int lo_len_i,
   // command towards the laser
   output logic pwm_cmd_o
);
   int cnt_q = 0;

   // fixed period with no jitter, steady level when one length is zero
   always @(posedge ref_clk_i)
      cnt_q <= (cnt_q + 1 >= hi_len_i + lo_len_i) ? 0 : cnt_q + 1;

   // normally-off gate: low gate locks the beam off
   assign pwm_cmd_o = gate_i && (cnt_q < hi_len_i);
endmodule

// ===== tb/laser_enable_status_tickle_test.sv
// self-checking bench for lest_top with shortened inhibit and window
// assumes lest_ctrl_model drives the command; bench drives other inputs
`timescale 1ns/10ps
module laser_enable_status_tickle_test
   import lest_pkg::*;
;
   localparam int INH = 200;
   localparam int WIN = 50;
   localparam int TLEN = 5;
   logic ref_clk_i = 0;
   logic reset_i = 1;
   logic remote_reset_i = 1;
   // interlock held closed by the far side when unused
   logic interlock_i = 1;
   logic over_temp_i = 0;
   logic gate = 1;
   int hi_len = 1;
   int lo_len = 0;
   logic [7:0] avs_address_i = 8'h00;
   logic avs_read_i = 0;
   logic avs_write_i = 0;
   logic [3:0] avs_byteenable_i = 4'hf;
   logic [31:0] avs_writedata_i = 32'h0;
   wire logic pwm_cmd_i, rf_drive_o, tickle_o, lasing_o, over_temp_o, ready_o, interlock_open_o;
   wire logic avs_waitrequest_o, irq_o;
   wire logic [31:0] avs_readdata_o;
   wire logic [2:0] obs = {tickle_o, lasing_o, ready_o};
   int errors = 0;
   int n_checks = 0;
   int n;
   logic [31:0] rd;

   initial forever #2 ref_clk_i = ~ref_clk_i;

   lest_ctrl_model pm_u (.ref_clk_i, .gate_i(gate), .hi_len_i(hi_len), .lo_len_i(lo_len), .pwm_cmd_o(pwm_cmd_i));
   lest_top #(.INHIBIT_CYCLES(INH), .TICKLE_WIN_CYCLES(WIN)) dut_u (
      .ref_clk_i, .reset_i, .pwm_cmd_i, .remote_reset_i, .interlock_i, .over_temp_i, .rf_drive_o,
      .tickle_o, .lasing_o, .over_temp_o, .ready_o, .interlock_open_o, .avs_address_i, .avs_read_i,
      .avs_write_i, .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .irq_o
   );

   task tally_and_finish;
      if (errors == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one bus cycle; the extra edge keeps back-to-back calls apart
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      do
      begin
         @(posedge ref_clk_i);
         k++;
      end while (avs_waitrequest_o !== 1'b0 && k < 20);
      if (k == 20)
      begin
         errors++;
         tally_and_finish;
      end
      rd = avs_readdata_o;
      avs_write_i <= 0;
      avs_read_i <= 0;
      @(posedge ref_clk_i);
   endtask

   task cyc(input int c);
      repeat (c) @(posedge ref_clk_i);
   endtask

   task wait_on(input int b, input logic v, input int lim);
      n = 0;
      while (obs[b] !== v && n < lim)
      begin
         @(posedge ref_clk_i);
         n++;
      end
   endtask

   task hi_cnt(input int c);
      n = 0;
      repeat (c)
      begin
         @(posedge ref_clk_i);
         n += (tickle_o === 1'b1);
      end
   endtask

   initial
   begin
      cyc(5);
      reset_i <= 0;
      cyc(2);
      chk("waitrequest", 1, avs_waitrequest_o);
      bus(0, REG_CTRL, 0);
      chk("ctrl", 32'h1, rd);
      bus(0, REG_TICKLE_LEN, 0);
      chk("tickle len reg", 32'h3e8, rd);
      bus(0, REG_IRQ_MASK, 0);
      chk("mask", 32'h0, rd);
      bus(0, 8'h20, 0);
      chk("unmapped", 32'h0, rd);
      bus(1, REG_TICKLE_LEN, TLEN);
      avs_byteenable_i <= 4'h2;
      bus(1, REG_TICKLE_LEN, 32'h0000_ab00);
      avs_byteenable_i <= 4'hf;
      bus(0, REG_TICKLE_LEN, 0);
      chk("byte lane", 32'hab05, rd);
      bus(1, REG_TICKLE_LEN, TLEN);
      bus(1, REG_IRQ_MASK, 32'h1f);
      cyc(20);
      chk("ready in reset", 0, ready_o);
      remote_reset_i <= 0;
      wait_on(0, 1, 10);
      chk("ready rise", 1, n < 10);
      wait_on(1, 1, INH - 10);
      chk("inhibit", INH - 10, n);
      chk("drive inhibit", 0, rf_drive_o);
      wait_on(1, 1, 30);
      chk("lasing", 1, n < 30);
      cyc(100);
      chk("cw drive", 1, rf_drive_o);
      bus(0, REG_STATUS, 0);
      chk("status", 32'h07, rd);
      chk("irq", 1, irq_o);
      bus(0, REG_IRQ_STAT, 0);
      chk("irq stat", 32'h03, rd);
      bus(1, REG_IRQ_STAT, 32'h03);
      bus(1, REG_IRQ_MASK, 32'h0c);
      cyc(2);
      chk("irq clear", 0, irq_o);
      hi_len <= 0;
      lo_len <= 1;
      wait_on(2, 1, WIN + 20);
      chk("tickle delay", 1, n >= WIN && n < WIN + 8);
      wait_on(2, 0, 20);
      chk("tickle width", TLEN, n);
      bus(0, REG_IRQ_STAT, 0);
      chk("tickle event", 32'h10, rd);
      chk("masked irq", 0, irq_o);
      hi_len <= 20;
      lo_len <= WIN - 10;
      cyc(20);
      hi_cnt(600);
      chk("short gaps", 0, n);
      lo_len <= WIN + 20;
      hi_cnt(900);
      chk("long gaps", 1, n > 0);
      hi_len <= 1;
      lo_len <= 0;
      over_temp_i <= 1;
      cyc(10);
      chk("over temp", 1, over_temp_o);
      bus(0, REG_STATUS, 0);
      chk("status hot", 32'h0f, rd);
      chk("irq temp", 1, irq_o);
      over_temp_i <= 0;
      bus(1, REG_IRQ_STAT, 32'h1f);
      cyc(10);
      chk("temp clear", 0, over_temp_o);
      chk("irq cleared", 0, irq_o);
      interlock_i <= 0;
      wait_on(0, 0, 10);
      chk("ilk drop", 1, n < 10);
      cyc(2);
      chk("ilk open", 1, interlock_open_o);
      chk("drive off", 0, rf_drive_o);
      chk("irq ilk", 1, irq_o);
      interlock_i <= 1;
      wait_on(0, 1, 10);
      chk("ilk back", 1, n < 10);
      cyc(5);
      chk("ilk closed", 0, interlock_open_o);
      wait_on(1, 1, INH - 10);
      chk("reinhibit", INH - 10, n);
      wait_on(1, 1, 30);
      chk("relase", 1, n < 30);
      gate <= 0;
      cyc(8);
      chk("gate off", 0, lasing_o);
      wait_on(2, 1, WIN + 20);
      chk("gated tickle", 1, n > 0 && n < WIN + 20);
      bus(1, REG_CTRL, 32'h0);
      cyc(10);
      hi_cnt(WIN * 2);
      chk("tickle disabled", 0, n);
      gate <= 1;
      bus(1, REG_CTRL, 32'h3);
      wait_on(0, 0, 10);
      chk("hold drop", 1, n < 10);
      chk("hold drive", 0, rf_drive_o);
      bus(1, REG_CTRL, 32'h1);
      wait_on(0, 1, 10);
      chk("hold release", 1, n < 10);
      wait_on(1, 1, INH - 10);
      chk("hold inhibit", INH - 10, n);
      remote_reset_i <= 1;
      wait_on(0, 0, 10);
      chk("remote hold", 1, n < 10);
      cyc(INH + 20);
      chk("held off", 0, ready_o);
      chk("held no drive", 0, rf_drive_o);
      tally_and_finish;
   end
endmodule
